// ===== ldm_pkg.sv
// constants, field layout and carrier types for the laser sink lookup and monitor block
package ldm_pkg;
    localparam logic [7:0] ADDR_LIMIT_LAST = 8'h27;
    localparam logic [7:0] ADDR_RESULT_FIRST = 8'h60;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'h69;
    localparam logic [7:0] ADDR_CTRL = 8'h6e;
    localparam logic [7:0] ADDR_ALARM_HI = 8'h70;
    localparam logic [7:0] ADDR_ALARM_LO = 8'h71;
    localparam logic [7:0] ADDR_WARN_HI = 8'h74;
    localparam logic [7:0] ADDR_WARN_LO = 8'h75;
    localparam logic [7:0] ADDR_UPDATE = 8'h77;
    localparam logic [7:0] ADDR_MASK_FIRST = 8'h78;
    localparam logic [7:0] ADDR_MASK_LAST = 8'h7b;
    localparam logic [7:0] ADDR_TABLE_SEL = 8'h7f;
    localparam logic [7:0] ADDR_TABLE_CFG = 8'h80;
    localparam logic [7:0] ADDR_TEMP_IDX = 8'h81;
    localparam logic [7:0] ADDR_SINK_A = 8'h82;
    localparam logic [7:0] ADDR_SINK_B = 8'h83;
    localparam logic [7:0] ADDR_RANGE = 8'h88;
    localparam logic [7:0] ADDR_CAL_FIRST = 8'h8e;
    localparam logic [7:0] ADDR_CAL_LAST = 8'haf;
    localparam logic [7:0] ADDR_LUT_FIRST = 8'h80;
    localparam logic [7:0] ADDR_LUT_LAST = 8'hc7;
    localparam logic [7:0] TBL_LUT_A = 8'h02;
    localparam logic [7:0] TBL_LUT_B = 8'h03;
    localparam logic [7:0] TBL_CFG = 8'h04;
    // calibration byte positions relative to ADDR_CAL_FIRST
    localparam int CAL_BYTES = 34;
    localparam int CAL_GAIN_POS = 0;
    localparam int CAL_OFFS_POS = 8;
    localparam int CAL_SHIFT_A_POS = 20;
    localparam int CAL_SHIFT_B_POS = 21;
    localparam logic [7:0] GAIN_UNITY_MSB = 8'h80;
    localparam int CTRL_SOFT_DIS_BIT = 6;
    localparam int CTRL_RATE_PIN_BIT = 4;
    localparam int CTRL_SOFT_RATE_BIT = 3;
    localparam int CFG_TABLE_EN_BIT = 1;
    localparam int RANGE_A_BIT = 0;
    localparam int RANGE_B_BIT = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h02;
    localparam logic [7:0] RANGE_RESET = 8'h00;
    localparam logic [7:0] TABLE_SEL_RESET = 8'h04;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam int LUT_DEPTH = 72;
    localparam int NUM_CH = 5;
    localparam int LIMIT_BYTES = 40;
    localparam int TEMP_MIN_C = -40;
    localparam int STEP_C = 2;
    localparam int HYST_C = 1;
    localparam logic [2:0] CH_TEMP = 3'h0;
    localparam logic [2:0] CH_VCC = 3'h1;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ldm_host_req_t;

    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [12:0] raw;
    } ldm_adc_t;
endpackage

// ===== ldm_ctrl.sv
// laser sink lookup, calibration, limit checking and memory map
`timescale 1ns/1ns
module ldm_ctrl (
    input wire logic sys_clk,
    input wire logic srst,
    input wire ldm_pkg::ldm_host_req_t host_req,
    output logic [7:0] host_rdata,
    output logic host_rvalid,
    input wire ldm_pkg::ldm_adc_t adc_in,
    input wire logic tx_disable_pin,
    input wire logic rate_sel_in,
    output logic rate_sel_out_o,
    output logic rate_sel_out_oe,
    output logic [7:0] bias_sink_a,
    output logic bias_sink_a_oe,
    output logic sink_a_range_sel,
    output logic [7:0] bias_sink_b,
    output logic bias_sink_b_oe,
    output logic sink_b_range_sel,
    output logic masked_monitor_irq
);
    import ldm_pkg::*;

    logic [7:0] lim_r [LIMIT_BYTES];
    logic [7:0] lut_a_r [LUT_DEPTH];
    logic [7:0] lut_b_r [LUT_DEPTH];
    logic [7:0] cal_r [CAL_BYTES];
    logic [15:0] result_r [NUM_CH];
    logic [7:0] mask_r [4];
    logic [9:0] alarm_r;
    logic [9:0] warn_r;
    logic [4:0] upd_r;
    logic [7:0] ctrl_r;
    logic [7:0] cfg_r;
    logic [7:0] range_r;
    logic [7:0] tbl_sel_r;
    logic [6:0] idx_r;
    logic [7:0] sink_a_r;
    logic [7:0] sink_b_r;
    logic [7:0] rdata_r;
    logic rvalid_r;

    logic table_index_enable;
    logic sink_off;
    logic conv;
    logic temp_conv;
    logic [15:0] cal_val;
    logic [6:0] idx_nxt;
    logic [7:0] rdata_nxt;
    logic [9:0] flag_src;
    logic wr_cfg_tbl;

    assign table_index_enable = cfg_r[CFG_TABLE_EN_BIT];
    assign conv = adc_in.valid && (adc_in.chan < 3'(NUM_CH));
    assign temp_conv = conv && (adc_in.chan == CH_TEMP);
    assign wr_cfg_tbl = host_req.wr && host_req.addr[7] && (tbl_sel_r == TBL_CFG);

    // gain is q1.15 so 8000h is unity; offset is signed and the sum saturates
    function automatic logic [15:0] cal_apply(input logic [2:0] ch, input logic [12:0] raw);
        logic [15:0] left;
        logic [15:0] gain;
        logic [15:0] offs;
        logic [2:0] sh;
        logic [31:0] prod;
        logic signed [17:0] sum;
        int p;
        left = {raw, 3'h0};
        p = CAL_OFFS_POS + 2 * int'(ch);
        offs = {cal_r[p], cal_r[p + 1]};
        if (ch == CH_TEMP) begin
            sum = 18'(signed'(left)) + 18'(signed'(offs));
            if (sum > 18'sh07fff) begin
                cal_apply = 16'h7fff;
            end else if (sum < -18'sh08000) begin
                cal_apply = 16'h8000;
            end else begin
                cal_apply = sum[15:0];
            end
        end else begin
            p = CAL_GAIN_POS + 2 * (int'(ch) - 1);
            gain = {cal_r[p], cal_r[p + 1]};
            prod = left * gain;
            sum = 18'(prod[31:15]) + 18'(signed'(offs));
            if (sum[17]) begin
                left = 16'h0000;
            end else if (sum[16]) begin
                left = 16'hffff;
            end else begin
                left = sum[15:0];
            end
            case (ch)
                3'h2: sh = cal_r[CAL_SHIFT_A_POS][2:0];
                3'h3: sh = cal_r[CAL_SHIFT_A_POS][6:4];
                3'h4: sh = cal_r[CAL_SHIFT_B_POS][2:0];
                default: sh = 3'h0;
            endcase
            cal_apply = left >> sh;
        end
    endfunction

    // limit compare; temperature is two's complement, the rest unsigned
    function automatic logic over(input logic sgn, input logic [15:0] a, input logic [15:0] b);
        over = sgn ? (signed'(a) > signed'(b)) : (a > b);
    endfunction

    function automatic logic under(input logic sgn, input logic [15:0] a, input logic [15:0] b);
        under = sgn ? (signed'(a) < signed'(b)) : (a < b);
    endfunction

    // a process, not an assign, so calibration byte writes re-evaluate it too
    always_comb begin
        cal_val = cal_apply(adc_in.chan, adc_in.raw);
    end

    // band for index i is [2i-41, 2i-38): 1 degree overlap with each neighbour
    always_comb begin
        logic signed [9:0] t;
        logic signed [9:0] i;
        logic signed [9:0] cand;
        t = 10'(signed'(cal_val[15:8]));
        i = signed'({3'h0, idx_r});
        cand = i;
        if (t >= 10'(TEMP_MIN_C) + 10'(STEP_C) * (i + 10'sd1)) begin
            cand = (t - 10'(TEMP_MIN_C)) >>> 1;
        end else if (t < 10'(TEMP_MIN_C) + 10'(STEP_C) * (i - 10'sd1) + 10'(HYST_C)) begin
            cand = (t - 10'(TEMP_MIN_C) + 10'(HYST_C)) >>> 1;
        end
        if (cand < 10'sd0) begin
            idx_nxt = 7'h00;
        end else if (cand > 10'(LUT_DEPTH - 1)) begin
            idx_nxt = 7'(LUT_DEPTH - 1);
        end else begin
            idx_nxt = cand[6:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            idx_r <= 7'h00;
        end else if (temp_conv && table_index_enable) begin
            idx_r <= idx_nxt;
        end
    end

    // hardware load wins over a host write landing in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sink_a_r <= 8'h00;
            sink_b_r <= 8'h00;
        end else if (temp_conv && table_index_enable) begin
            sink_a_r <= lut_a_r[idx_nxt];
            sink_b_r <= lut_b_r[idx_nxt];
        end else if (wr_cfg_tbl) begin
            if (host_req.addr == ADDR_SINK_A) begin
                sink_a_r <= host_req.wdata;
            end
            if (host_req.addr == ADDR_SINK_B) begin
                sink_b_r <= host_req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int k = 0; k < LUT_DEPTH; k++) begin
                lut_a_r[k] <= 8'h00;
                lut_b_r[k] <= 8'h00;
            end
        end else if (host_req.wr && host_req.addr >= ADDR_LUT_FIRST && host_req.addr <= ADDR_LUT_LAST) begin
            if (tbl_sel_r == TBL_LUT_A) begin
                lut_a_r[7'(host_req.addr - ADDR_LUT_FIRST)] <= host_req.wdata;
            end
            if (tbl_sel_r == TBL_LUT_B) begin
                lut_b_r[7'(host_req.addr - ADDR_LUT_FIRST)] <= host_req.wdata;
            end
        end
    end

    // gains come out of reset at unity so raw results pass through
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int k = 0; k < CAL_BYTES; k++) begin
                cal_r[k] <= (k < CAL_OFFS_POS && k % 2 == 0) ? GAIN_UNITY_MSB : 8'h00;
            end
        end else if (wr_cfg_tbl && host_req.addr >= ADDR_CAL_FIRST && host_req.addr <= ADDR_CAL_LAST) begin
            cal_r[6'(host_req.addr - ADDR_CAL_FIRST)] <= host_req.wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_r <= CFG_RESET;
            range_r <= RANGE_RESET;
        end else if (wr_cfg_tbl) begin
            if (host_req.addr == ADDR_TABLE_CFG) begin
                cfg_r <= host_req.wdata;
            end
            if (host_req.addr == ADDR_RANGE) begin
                range_r <= host_req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int k = 0; k < LIMIT_BYTES; k++) begin
                lim_r[k] <= 8'h00;
            end
        end else if (host_req.wr && host_req.addr <= ADDR_LIMIT_LAST) begin
            lim_r[6'(host_req.addr)] <= host_req.wdata;
        end
    end

    // only the two soft control bits are writable; bit 4 is live pin state
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RESET;
            tbl_sel_r <= TABLE_SEL_RESET;
            for (int k = 0; k < 4; k++) begin
                mask_r[k] <= MASK_RESET;
            end
        end else if (host_req.wr) begin
            if (host_req.addr == ADDR_CTRL) begin
                ctrl_r[CTRL_SOFT_DIS_BIT] <= host_req.wdata[CTRL_SOFT_DIS_BIT];
                ctrl_r[CTRL_SOFT_RATE_BIT] <= host_req.wdata[CTRL_SOFT_RATE_BIT];
            end
            if (host_req.addr == ADDR_TABLE_SEL) begin
                tbl_sel_r <= host_req.wdata;
            end
            if (host_req.addr >= ADDR_MASK_FIRST && host_req.addr <= ADDR_MASK_LAST) begin
                mask_r[2'(host_req.addr - ADDR_MASK_FIRST)] <= host_req.wdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            for (int k = 0; k < NUM_CH; k++) begin
                result_r[k] <= 16'h0000;
            end
        end else if (conv) begin
            result_r[adc_in.chan] <= cal_val;
        end
    end

    // flags follow the latest result of their own channel only
    always_ff @(posedge sys_clk) begin
        logic sgn;
        int b;
        int p;
        sgn = (adc_in.chan == CH_TEMP);
        b = 9 - 2 * int'(adc_in.chan);
        p = 8 * int'(adc_in.chan);
        if (srst) begin
            alarm_r <= 10'h000;
            warn_r <= 10'h000;
        end else if (conv) begin
            alarm_r[b] <= over(sgn, cal_val, {lim_r[p], lim_r[p + 1]});
            alarm_r[b - 1] <= under(sgn, cal_val, {lim_r[p + 2], lim_r[p + 3]});
            warn_r[b] <= over(sgn, cal_val, {lim_r[p + 4], lim_r[p + 5]});
            warn_r[b - 1] <= under(sgn, cal_val, {lim_r[p + 6], lim_r[p + 7]});
        end
    end

    // reading the update byte clears it; a completion in that cycle survives
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            upd_r <= 5'h00;
        end else begin
            for (int k = 0; k < NUM_CH; k++) begin
                if (conv && adc_in.chan == 3'(k)) begin
                    upd_r[4 - k] <= 1'b1;
                end else if (host_req.rd && host_req.addr == ADDR_UPDATE) begin
                    upd_r[4 - k] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (host_req.addr <= ADDR_LIMIT_LAST) begin
            rdata_nxt = lim_r[6'(host_req.addr)];
        end else if (host_req.addr >= ADDR_RESULT_FIRST && host_req.addr <= ADDR_RESULT_LAST) begin
            rdata_nxt = host_req.addr[0] ? result_r[3'(host_req.addr[3:1])][7:0]
                                         : result_r[3'(host_req.addr[3:1])][15:8];
        end else if (host_req.addr >= ADDR_MASK_FIRST && host_req.addr <= ADDR_MASK_LAST) begin
            rdata_nxt = mask_r[2'(host_req.addr - ADDR_MASK_FIRST)];
        end else if (host_req.addr >= ADDR_LUT_FIRST && host_req.addr <= ADDR_LUT_LAST
                     && tbl_sel_r == TBL_LUT_A) begin
            rdata_nxt = lut_a_r[7'(host_req.addr - ADDR_LUT_FIRST)];
        end else if (host_req.addr >= ADDR_LUT_FIRST && host_req.addr <= ADDR_LUT_LAST
                     && tbl_sel_r == TBL_LUT_B) begin
            rdata_nxt = lut_b_r[7'(host_req.addr - ADDR_LUT_FIRST)];
        end else if (host_req.addr >= ADDR_CAL_FIRST && host_req.addr <= ADDR_CAL_LAST
                     && tbl_sel_r == TBL_CFG) begin
            rdata_nxt = cal_r[6'(host_req.addr - ADDR_CAL_FIRST)];
        end else begin
            case (host_req.addr)
                ADDR_CTRL: begin
                    rdata_nxt = ctrl_r;
                    rdata_nxt[CTRL_RATE_PIN_BIT] = rate_sel_in;
                end
                ADDR_ALARM_HI: rdata_nxt = alarm_r[9:2];
                ADDR_ALARM_LO: rdata_nxt = {alarm_r[1:0], 6'h00};
                ADDR_WARN_HI: rdata_nxt = warn_r[9:2];
                ADDR_WARN_LO: rdata_nxt = {warn_r[1:0], 6'h00};
                ADDR_UPDATE: rdata_nxt = {upd_r, 3'h0};
                ADDR_TABLE_SEL: rdata_nxt = tbl_sel_r;
                ADDR_TABLE_CFG: rdata_nxt = (tbl_sel_r == TBL_CFG) ? cfg_r : 8'h00;
                ADDR_TEMP_IDX: rdata_nxt = (tbl_sel_r == TBL_CFG) ? ADDR_LUT_FIRST + 8'(idx_r) : 8'h00;
                ADDR_SINK_A: rdata_nxt = (tbl_sel_r == TBL_CFG) ? sink_a_r : 8'h00;
                ADDR_SINK_B: rdata_nxt = (tbl_sel_r == TBL_CFG) ? sink_b_r : 8'h00;
                ADDR_RANGE: rdata_nxt = (tbl_sel_r == TBL_CFG) ? range_r : 8'h00;
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= host_req.rd ? rdata_nxt : rdata_r;
            rvalid_r <= host_req.rd;
        end
    end

    assign host_rdata = rdata_r;
    assign host_rvalid = rvalid_r;
    assign sink_off = tx_disable_pin || ctrl_r[CTRL_SOFT_DIS_BIT];
    assign bias_sink_a = sink_a_r;
    assign bias_sink_b = sink_b_r;
    assign bias_sink_a_oe = !sink_off;
    assign bias_sink_b_oe = !sink_off;
    assign sink_a_range_sel = range_r[RANGE_A_BIT];
    assign sink_b_range_sel = range_r[RANGE_B_BIT];
    // open drain: pulls low only when the selected rate is low
    assign rate_sel_out_o = 1'b0;
    assign rate_sel_out_oe = !(rate_sel_in || ctrl_r[CTRL_SOFT_RATE_BIT]);
    assign flag_src = (alarm_r & {mask_r[0], mask_r[1][7:6]})
                    | (warn_r & {mask_r[2], mask_r[3][7:6]});
    assign masked_monitor_irq = |flag_src;

    sequence temp_update_s;
        temp_conv && table_index_enable;
    endsequence

    sequence host_sink_write_s;
        wr_cfg_tbl && host_req.addr == ADDR_SINK_A;
    endsequence

    sink_hiz_pin_a: assert property (@(posedge sys_clk) disable iff (srst)
        tx_disable_pin |-> !bias_sink_a_oe && !bias_sink_b_oe)
        else $error("sink driven while disable pin high");
    sink_hiz_soft_a: assert property (@(posedge sys_clk) disable iff (srst)
        ctrl_r[CTRL_SOFT_DIS_BIT] |-> !bias_sink_a_oe && !bias_sink_b_oe)
        else $error("sink driven while soft disable set");
    range_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
        host_req.wr && host_req.addr == ADDR_RANGE && tbl_sel_r == TBL_CFG
        |=> sink_a_range_sel == $past(host_req.wdata[RANGE_A_BIT]))
        else $error("range select not taken from range byte");
    rate_out_a: assert property (@(posedge sys_clk) disable iff (srst)
        (rate_sel_in || ctrl_r[CTRL_SOFT_RATE_BIT]) != rate_sel_out_oe)
        else $error("rate output not the OR of pin and bit");
    rate_pin_read_a: assert property (@(posedge sys_clk) disable iff (srst)
        host_req.rd && host_req.addr == ADDR_CTRL |=> host_rdata[CTRL_RATE_PIN_BIT] == $past(rate_sel_in))
        else $error("rate pin state not read back");
    auto_load_a: assert property (@(posedge sys_clk) disable iff (srst)
        temp_update_s |=> sink_a_r == lut_a_r[idx_r] && sink_b_r == lut_b_r[idx_r])
        else $error("sink settings not loaded from table");
    auto_overwrite_a: assert property (@(posedge sys_clk) disable iff (srst)
        host_sink_write_s ##[1:8] temp_update_s |=> sink_a_r == lut_a_r[idx_r])
        else $error("host sink write survived table update");
    manual_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
        !table_index_enable && !host_req.wr |=> $stable(sink_a_r) && $stable(idx_r))
        else $error("sink changed in manual mode");
    cold_clamp_a: assert property (@(posedge sys_clk) disable iff (srst)
        temp_update_s and signed'(cal_val[15:8]) < -8'sd41 |=> idx_r == 7'h00)
        else $error("cold temperature not clamped to first entry");
    update_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
        conv && adc_in.chan == CH_VCC |=> upd_r[3])
        else $error("update bit not set after conversion");
    irq_follow_a: assert property (@(posedge sys_clk) disable iff (srst)
        conv && mask_r[0] == 8'hff && $stable(mask_r[0]) && adc_in.chan == CH_TEMP
        && over(1'b1, cal_val, {lim_r[0], lim_r[1]}) |=> masked_monitor_irq)
        else $error("enabled alarm did not raise fault output");
endmodule

// ===== ldm_host.sv
// host model issuing single byte writes and reads on the register port
`timescale 1ns/1ns
module ldm_host (
    input wire logic sys_clk,
    output ldm_pkg::ldm_host_req_t req,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    import ldm_pkg::*;
    initial req = '0;
    // released address is inverted so a stale value is never mistaken for a held one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge sys_clk);
        req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // answer stands one cycle, so it is taken at the falling edge inside it
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(negedge sys_clk);
        d = rdata;
        ok = rvalid;
        req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    endtask
endmodule

// ===== ldm_ctrl_bench.sv
// self-checking bench for the sink lookup and monitor control block
`timescale 1ns/1ns
module ldm_ctrl_bench;
    import ldm_pkg::*;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    ldm_host_req_t req;
    ldm_adc_t adc = '0;
    logic txd = 1'b0;
    logic rate_in = 1'b1;
    logic [7:0] rdata, sa, sb;
    logic rvalid, rate_o, rate_oe, sa_oe, ra, sb_oe, rb, irq;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    ldm_host host (.sys_clk(sys_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
    ldm_ctrl dut (.sys_clk(sys_clk), .srst(srst), .host_req(req), .host_rdata(rdata), .host_rvalid(rvalid),
        .adc_in(adc), .tx_disable_pin(txd), .rate_sel_in(rate_in), .rate_sel_out_o(rate_o),
        .rate_sel_out_oe(rate_oe), .bias_sink_a(sa), .bias_sink_a_oe(sa_oe), .sink_a_range_sel(ra),
        .bias_sink_b(sb), .bias_sink_b_oe(sb_oe), .sink_b_range_sel(rb), .masked_monitor_irq(irq));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        host.rd(a, v, ok);
        chk({7'h0, ok}, 8'h01);
        chk(v, exp);
    endtask
    task automatic conv(input logic [2:0] ch, input logic [12:0] raw);
        @(negedge sys_clk);
        adc <= '{valid: 1'b1, chan: ch, raw: raw};
        @(negedge sys_clk);
        adc.valid <= 1'b0;
    endtask
    task automatic t_reset;
        rchk(ADDR_CTRL, 8'h10);
        rchk(ADDR_TABLE_CFG, 8'h02);
        rchk(8'h50, 8'h00);
    endtask
    task automatic t_pins;
        chk({sa_oe, sb_oe, rate_oe}, 8'h06);
        chk({7'h0, rate_o}, 8'h00);
        @(negedge sys_clk);
        rate_in = 1'b0;
        #1 chk({7'h0, rate_oe}, 8'h01);
        host.wr(ADDR_CTRL, 8'h08);
        chk({7'h0, rate_oe}, 8'h00);
        rchk(ADDR_CTRL, 8'h08);
        txd = 1'b1;
        #1 chk({sa_oe, sb_oe}, 8'h00);
        txd = 1'b0;
        host.wr(ADDR_CTRL, 8'h40);
        chk({sa_oe, sb_oe}, 8'h00);
        host.wr(ADDR_CTRL, 8'h00);
        chk({sa_oe, sb_oe}, 8'h03);
    endtask
    task automatic t_range;
        host.wr(ADDR_RANGE, 8'h01);
        chk({ra, rb}, 8'h02);
        host.wr(ADDR_RANGE, 8'h02);
        chk({ra, rb}, 8'h01);
    endtask
    // 1/32 degree per raw step: 25C=320h, 23C=2e0h, -60C=1880h, +120C=f00h
    task automatic t_lut;
        host.wr(ADDR_TABLE_SEL, TBL_LUT_A);
        host.wr(8'ha0, 8'h5a);
        host.wr(8'h80, 8'h11);
        host.wr(8'hc7, 8'h77);
        host.wr(ADDR_TABLE_SEL, TBL_LUT_B);
        host.wr(8'ha0, 8'ha5);
        host.wr(ADDR_TABLE_SEL, TBL_CFG);
        conv(CH_TEMP, 13'h0320);
        rchk(ADDR_TEMP_IDX, 8'ha0);
        chk(sa, 8'h5a);
        chk(sb, 8'ha5);
        conv(CH_TEMP, 13'h02e0);
        rchk(ADDR_TEMP_IDX, 8'ha0);
        host.wr(ADDR_SINK_A, 8'hff);
        conv(CH_TEMP, 13'h0320);
        chk(sa, 8'h5a);
        conv(CH_TEMP, 13'h1880);
        rchk(ADDR_TEMP_IDX, 8'h80);
        chk(sa, 8'h11);
        conv(CH_TEMP, 13'h0f00);
        rchk(ADDR_TEMP_IDX, 8'hc7);
        chk(sa, 8'h77);
        chk(sb, 8'h00);
    endtask
    task automatic t_manual;
        host.wr(ADDR_TABLE_CFG, 8'h00);
        host.wr(ADDR_SINK_A, 8'h3c);
        conv(CH_TEMP, 13'h0320);
        chk(sa, 8'h3c);
        rchk(ADDR_TEMP_IDX, 8'hc7);
        host.wr(ADDR_TABLE_CFG, 8'h02);
    endtask
    task automatic t_monitor;
        conv(CH_TEMP, 13'h0320);
        rchk(8'h60, 8'h19);
        rchk(8'h61, 8'h00);
        conv(CH_VCC, 13'h1fff);
        rchk(8'h62, 8'hff);
        rchk(8'h63, 8'hf8);
        rchk(ADDR_UPDATE, 8'hc0);
        rchk(ADDR_UPDATE, 8'h00);
        rchk(ADDR_ALARM_HI, 8'ha0);
        rchk(ADDR_WARN_HI, 8'ha0);
        chk({7'h0, irq}, 8'h00);
        host.wr(ADDR_MASK_FIRST, 8'h20);
        chk({7'h0, irq}, 8'h01);
        host.wr(ADDR_MASK_FIRST, 8'hff);
        conv(CH_TEMP, 13'h0320);
        chk({7'h0, irq}, 8'h01);
        host.wr(ADDR_MASK_FIRST, 8'h00);
        host.wr(8'h08, 8'hff);
        host.wr(8'h09, 8'hf8);
        conv(CH_VCC, 13'h1fff);
        rchk(ADDR_ALARM_HI, 8'h80);
    endtask
    task automatic t_shift;
        host.wr(8'ha2, 8'h21);
        conv(3'h2, 13'h1000);
        rchk(8'h64, 8'h40);
        rchk(8'h65, 8'h00);
        conv(3'h3, 13'h1000);
        rchk(8'h66, 8'h20);
        host.wr(8'ha3, 8'h07);
        conv(3'h4, 13'h1fff);
        rchk(8'h68, 8'h01);
        rchk(8'h69, 8'hff);
        host.wr(8'h90, 8'h40);
        conv(3'h2, 13'h1000);
        rchk(8'h64, 8'h20);
        host.wr(8'h96, 8'h01);
        conv(CH_TEMP, 13'h0320);
        rchk(8'h60, 8'h1a);
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // the whole sequence needs well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        srst = 1'b0;
        t_reset();
        t_pins();
        t_range();
        t_lut();
        t_manual();
        t_monitor();
        t_shift();
        print_verdict();
    end
endmodule
